// File: hw/uartrb_pkg.sv
package uartrb_pkg;

    // vendor request shape
    localparam logic [7:0]  REQT_WR      = 8'h41;
    localparam logic [7:0]  REQT_RD      = 8'hC1;
    localparam logic [7:0]  REQ_REG      = 8'h00;
    localparam logic [15:0] RD_LEN       = 16'h0002;
    localparam logic [7:0]  IDX_HI_ZERO  = 8'h00;

    // register offsets (low byte of the request index)
    localparam logic [7:0] A_PORT_EN     = 8'h40;
    localparam logic [7:0] A_CHAR_FMT    = 8'h45;
    localparam logic [7:0] A_FLOW_SEL    = 8'h46;
    localparam logic [7:0] A_RESUME_CH   = 8'h47;
    localparam logic [7:0] A_PAUSE_CH    = 8'h48;
    localparam logic [7:0] A_LINE_ERR    = 8'h49;
    localparam logic [7:0] A_BRK_DUR     = 8'h4A;
    localparam logic [7:0] A_DRV_DLY     = 8'h4B;
    localparam logic [7:0] A_PIN_FUNC    = 8'h4C;
    localparam logic [7:0] A_PIN_DIR     = 8'h4D;
    localparam logic [7:0] A_PIN_SET     = 8'h4E;
    localparam logic [7:0] A_PIN_CLR     = 8'h4F;
    localparam logic [7:0] A_PIN_LVL     = 8'h50;
    localparam logic [7:0] A_PIN_IMASK   = 8'h51;
    localparam logic [7:0] A_CUST_INT    = 8'h52;
    localparam logic [7:0] A_PULLUP      = 8'h54;
    localparam logic [7:0] A_PULLDN      = 8'h55;
    localparam logic [7:0] A_LOOP_SEL    = 8'h56;
    localparam logic [7:0] A_INFRARED_MODE     = 8'h57;
    localparam logic [7:0] A_WAKE_EN     = 8'h5F;
    localparam logic [7:0] A_TXQ_FLUSH   = 8'h60;
    localparam logic [7:0] A_TXQ_LVL     = 8'h61;
    localparam logic [7:0] A_TX_WIDE     = 8'h62;
    localparam logic [7:0] A_RXQ_FLUSH   = 8'h63;
    localparam logic [7:0] A_RXQ_LVL     = 8'h64;
    localparam logic [7:0] A_RX_WIDE     = 8'h65;
    localparam logic [7:0] A_RX_PKT      = 8'h66;
    localparam logic [7:0] A_FLOW_TRIG   = 8'h67;
    localparam logic [7:0] A_DRV_FLAG    = 8'h81;

    localparam int NREG = 29;

    // slot numbers the logic looks at by name
    localparam int SL_EN    = 0;
    localparam int SL_FMT   = 1;
    localparam int SL_ERR   = 5;
    localparam int SL_PSET  = 10;
    localparam int SL_PCLR  = 11;
    localparam int SL_PLVL  = 12;
    localparam int SL_TXF   = 20;
    localparam int SL_TXL   = 21;
    localparam int SL_RXF   = 23;
    localparam int SL_RXL   = 24;
    localparam logic [4:0] SL_NONE = 5'h1F;

    localparam logic [7:0] REG_ADDR [NREG] = '{
        A_PORT_EN, A_CHAR_FMT, A_FLOW_SEL, A_RESUME_CH, A_PAUSE_CH, A_LINE_ERR,
        A_BRK_DUR, A_DRV_DLY, A_PIN_FUNC, A_PIN_DIR, A_PIN_SET, A_PIN_CLR,
        A_PIN_LVL, A_PIN_IMASK, A_CUST_INT, A_PULLUP, A_PULLDN, A_LOOP_SEL,
        A_INFRARED_MODE, A_WAKE_EN, A_TXQ_FLUSH, A_TXQ_LVL, A_TX_WIDE, A_RXQ_FLUSH,
        A_RXQ_LVL, A_RX_WIDE, A_RX_PKT, A_FLOW_TRIG, A_DRV_FLAG};

    typedef enum logic [1:0] {ACC_RW, ACC_RO, ACC_WO} uartrb_acc_t;

    localparam uartrb_acc_t REG_ACC [NREG] = '{
        ACC_RW, ACC_RW, ACC_RW, ACC_RW, ACC_RW, ACC_RO,
        ACC_RW, ACC_RW, ACC_RW, ACC_RW, ACC_WO, ACC_WO,
        ACC_RO, ACC_RW, ACC_RW, ACC_RW, ACC_RW, ACC_RW,
        ACC_RW, ACC_RW, ACC_WO, ACC_RO, ACC_RW, ACC_WO,
        ACC_RO, ACC_RW, ACC_RW, ACC_RW, ACC_RW};

    // reset values
    localparam logic [15:0] RST_ZERO     = 16'h0000;
    localparam logic [15:0] RST_CHAR_FMT = 16'h0008;
    localparam logic [15:0] RST_RESUME   = 16'h0011;
    localparam logic [15:0] RST_PAUSE    = 16'h0013;

    localparam logic [15:0] REG_RST [NREG] = '{
        RST_ZERO, RST_CHAR_FMT, RST_ZERO, RST_RESUME, RST_PAUSE, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};

    // implemented bits; the rest read as zero
    localparam logic [15:0] M_EN   = 16'h0003;
    localparam logic [15:0] M_B8   = 16'h00FF;
    localparam logic [15:0] M_B4   = 16'h000F;
    localparam logic [15:0] M_B6   = 16'h003F;
    localparam logic [15:0] M_B1   = 16'h0001;
    localparam logic [15:0] M_B2   = 16'h0003;
    localparam logic [15:0] M_B3   = 16'h0007;
    localparam logic [15:0] M_WAKE = 16'h000C;
    localparam logic [15:0] M_ERR  = 16'h00F8;
    localparam logic [15:0] M_LVL  = 16'h07FF;
    localparam logic [15:0] M_ALL  = 16'hFFFF;

    localparam logic [15:0] REG_MASK [NREG] = '{
        M_EN, M_B8, M_B4, M_B8, M_B8, M_ERR,
        M_ALL, M_B4, M_B4, M_B6, M_B6, M_B6,
        M_B6, M_B6, M_B1, M_B8, M_B8, M_B3,
        M_B3, M_WAKE, M_B1, M_LVL, M_B1, M_B1,
        M_LVL, M_B1, M_B2, M_LVL, M_B1};

    // character format field positions
    localparam int FMT_STOP    = 7;
    localparam int FMT_PAR_LSB = 4;
    localparam int FMT_BIT_LSB = 0;

    localparam logic [2:0] PAR_NONE  = 3'h0;
    localparam logic [2:0] PAR_SPACE = 3'h4;
    localparam logic [3:0] BITS_7    = 4'h7;
    localparam logic [3:0] BITS_9    = 4'h9;

    // class line-coding codes
    localparam logic [7:0] LC_STOP_1  = 8'h00;
    localparam logic [7:0] LC_STOP_2  = 8'h02;
    localparam logic [7:0] LC_PAR_MAX = 8'h04;
    localparam logic [7:0] LC_BITS_7  = 8'h07;
    localparam logic [7:0] LC_BITS_9  = 8'h09;

    typedef struct packed {
        logic [7:0]  req_type;
        logic [7:0]  request;
        logic [15:0] value;
        logic [15:0] index;
        logic [15:0] length;
    } uartrb_setup_t;

    typedef struct packed {
        logic [31:0] baud;
        logic [7:0]  stop;
        logic [7:0]  parity;
        logic [7:0]  bits;
    } uartrb_lcode_t;

    typedef struct packed {
        logic       rx_en;
        logic       tx_en;
        logic       stop_two;
        logic [2:0] parity;
        logic [3:0] data_bits;
    } uartrb_ctrl_t;

endpackage : uartrb_pkg

// File: hw/uartrb_lcode_map.sv
// turns a class line-coding record into a character format byte
module uartrb_lcode_map
    import uartrb_pkg::*;
(
    // request
    input  wire uartrb_lcode_t lcode,
    // result
    output logic [7:0]         fmt,
    output logic               ok
);

    wire stop_ok = (lcode.stop == LC_STOP_1) || (lcode.stop == LC_STOP_2);
    wire par_ok  = lcode.parity <= LC_PAR_MAX;
    wire bits_ok = (lcode.bits >= LC_BITS_7) && (lcode.bits <= LC_BITS_9);

    // 1.5 stop bits and 5/6-bit characters have no format code: refused
    assign ok  = stop_ok && par_ok && bits_ok;              // [RULE12]
    assign fmt = {lcode.stop == LC_STOP_2, lcode.parity[2:0], lcode.bits[3:0]};

endmodule : uartrb_lcode_map

// File: hw/uartrb_bank.sv
// Notes on behaviour
// RULE1: vendor 0x41 writes, 0xC1 reads two bytes
// RULE2: unmapped addresses do nothing, read zero
// RULE3: host writes only mapped addresses
// RULE4: host keeps upper byte zero on narrow registers
// RULE5: same map for every port instance
// RULE6: every register is sixteen bits
// RULE7: bits reset to zero unless stated otherwise
// RULE8: enable bit1 receiver, bit0 transmitter, reset off
// RULE9: format bit7 selects one or two stops
// RULE10: format bits 6:4 select parity
// RULE11: format bits 3:0 select length, reset eight
// RULE12: line-coding request also sets format
// RULE13: read returns low byte then high byte
module uartrb_bank
    import uartrb_pkg::*;
(
    // clock and reset
    input  wire logic                  SYS_CLK,
    input  wire logic                  RST_B,
    // setup stage from the device controller
    input  wire logic                  SETUP_VALID,
    input  wire uartrb_setup_t         SETUP_PKT,
    // read data stage
    output logic                       RD_VALID,
    output logic [7:0]                 RD_BYTE,
    output logic                       RD_LAST,
    input  wire logic                  RD_READY,
    // class line-coding data stage
    input  wire logic                  LCODE_VALID,
    input  wire uartrb_lcode_t         LCODE,
    // state shown by the serial core
    input  wire logic [15:0]           LINE_ERR,
    input  wire logic [15:0]           PIN_LEVEL,
    input  wire logic [15:0]           TXQ_LEVEL,
    input  wire logic [15:0]           RXQ_LEVEL,
    // decoded configuration
    output uartrb_ctrl_t               PORT_CTRL,
    output logic [31:0]                BAUD_RATE,
    output logic [NREG*16-1:0]         CFG_WORDS,
    // side effects of accesses
    output logic                       PIN_SET_STB,
    output logic                       PIN_CLR_STB,
    output logic [15:0]                PIN_WR_DATA,
    output logic                       TXQ_FLUSH_STB,
    output logic                       RXQ_FLUSH_STB,
    output logic                       ERR_RD_STB,
    output logic                       REQ_REFUSED
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic [4:0] slot_of(input logic [7:0] addr);
        logic [4:0] s;
        s = SL_NONE;
        for (int i = 0; i < NREG; i++) begin
            if (REG_ADDR[i] == addr) begin
                s = 5'(i);
            end
        end
        return s;
    endfunction : slot_of

    function automatic logic slot_is(input logic [4:0] s, input int n);
        return s == 5'(n);
    endfunction : slot_is

    typedef enum logic [1:0] {RD_IDLE, RD_LOW, RD_HIGH} uartrb_rd_t;

    uartrb_rd_t       rd_state_q;
    uartrb_rd_t       rd_state_d;
    logic [15:0]      rd_word_q;
    logic [15:0]      rd_word_d;
    logic [15:0]      reg_q [NREG];
    logic [15:0]      ro_word;
    logic [15:0]      rd_src;
    logic [31:0]      baud_q;
    logic             pset_q;
    logic             pclr_q;
    logic             txf_q;
    logic             rxf_q;
    logic             errrd_q;
    logic             refused_q;
    logic [15:0]      pdata_q;
    logic [7:0]       lc_fmt;
    logic             lc_ok;

    // the same map serves every port; the host reaches a port by its bus address
    wire [7:0] req_addr = SETUP_PKT.index[7:0];                         // [RULE5]
    wire [4:0] req_slot = slot_of(req_addr);
    wire       mapped   = req_slot != SL_NONE;                          // [RULE2]

    wire wr_shape = (SETUP_PKT.req_type == REQT_WR) && (SETUP_PKT.request == REQ_REG)
                    && (SETUP_PKT.index[15:8] == IDX_HI_ZERO);          // [RULE1]
    wire rd_shape = (SETUP_PKT.req_type == REQT_RD) && (SETUP_PKT.request == REQ_REG)
                    && (SETUP_PKT.index[15:8] == IDX_HI_ZERO)
                    && (SETUP_PKT.length == RD_LEN);                    // [RULE1]
    wire vendor   = (SETUP_PKT.req_type == REQT_WR) || (SETUP_PKT.req_type == REQT_RD);

    wire wr_req   = SETUP_VALID && wr_shape;
    wire rd_req   = SETUP_VALID && rd_shape;
    wire wr_hit   = wr_req && mapped;
    wire wr_rw    = wr_hit && (REG_ACC[req_slot] == ACC_RW);
    wire wr_wo    = wr_hit && (REG_ACC[req_slot] == ACC_WO);
    wire bad_req  = SETUP_VALID && vendor && !wr_shape && !rd_shape;

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    uartrb_lcode_map u_lcode (
        .lcode (LCODE),
        .fmt   (lc_fmt),
        .ok    (lc_ok)
    );

    // a register write from the vendor path beats a line-coding update
    wire lc_load = LCODE_VALID && lc_ok && !(wr_rw && slot_is(req_slot, SL_FMT)); // [RULE12]

    generate
        for (genvar g = 0; g < NREG; g++) begin : g_reg
            localparam bit IS_RW  = REG_ACC[g] == ACC_RW;
            localparam bit IS_FMT = g == SL_FMT;
            wire        hit  = wr_rw && slot_is(req_slot, g);
            wire        lcld = IS_FMT && lc_load;
            wire [15:0] lcw  = {8'h00, lc_fmt} & REG_MASK[g];
            wire [15:0] wrw  = SETUP_PKT.value & REG_MASK[g];           // [RULE6]
            wire [15:0] nxt  = hit ? wrw : (lcld ? lcw : reg_q[g]);

            // masked storage drops the reserved upper byte the host should keep zero
            always_ff @(posedge SYS_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    reg_q[g] <= REG_RST[g];                             // [RULE7]
                end else if (IS_RW) begin
                    reg_q[g] <= nxt;                                    // [RULE4]
                end
            end

            assign CFG_WORDS[g*16 +: 16] = reg_q[g];
        end
    endgenerate

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            baud_q <= 32'h0000_0000;
        end else if (LCODE_VALID && lc_ok) begin
            baud_q <= LCODE.baud;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoded controls

    wire [15:0] en_w  = reg_q[SL_EN];
    wire [15:0] fmt_w = reg_q[SL_FMT];

    assign PORT_CTRL.rx_en     = en_w[1];                               // [RULE8]
    assign PORT_CTRL.tx_en     = en_w[0];                               // [RULE8]
    assign PORT_CTRL.stop_two  = fmt_w[FMT_STOP];                       // [RULE9]
    assign PORT_CTRL.parity    = fmt_w[FMT_PAR_LSB +: 3];               // [RULE10]
    assign PORT_CTRL.data_bits = fmt_w[FMT_BIT_LSB +: 4];               // [RULE11]
    assign BAUD_RATE           = baud_q;

    ////////////////////////////////////////////////////////////////////////////
    // write side effects, one cycle after the setup stage

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pset_q    <= 1'b0;
            pclr_q    <= 1'b0;
            txf_q     <= 1'b0;
            rxf_q     <= 1'b0;
            refused_q <= 1'b0;
            pdata_q   <= 16'h0000;
        end else begin
            pset_q    <= wr_wo && slot_is(req_slot, SL_PSET);
            pclr_q    <= wr_wo && slot_is(req_slot, SL_PCLR);
            txf_q     <= wr_wo && slot_is(req_slot, SL_TXF) && SETUP_PKT.value[0];
            rxf_q     <= wr_wo && slot_is(req_slot, SL_RXF) && SETUP_PKT.value[0];
            refused_q <= bad_req || (wr_req && !mapped);                // [RULE2]
            pdata_q   <= wr_wo ? (SETUP_PKT.value & REG_MASK[req_slot]) : pdata_q;
        end
    end

    assign PIN_SET_STB   = pset_q;
    assign PIN_CLR_STB   = pclr_q;
    assign PIN_WR_DATA   = pdata_q;
    assign TXQ_FLUSH_STB = txf_q;
    assign RXQ_FLUSH_STB = rxf_q;
    assign REQ_REFUSED   = refused_q;

    ////////////////////////////////////////////////////////////////////////////
    // read path

    assign ro_word = slot_is(req_slot, SL_ERR)  ? LINE_ERR  :
                     slot_is(req_slot, SL_PLVL) ? PIN_LEVEL :
                     slot_is(req_slot, SL_TXL)  ? TXQ_LEVEL :
                     slot_is(req_slot, SL_RXL)  ? RXQ_LEVEL : 16'h0000;

    // write-only and unmapped addresses read as zero
    assign rd_src = !mapped                        ? 16'h0000 :         // [RULE2]
                    (REG_ACC[req_slot] == ACC_RO)  ? (ro_word & REG_MASK[req_slot]) :
                    (REG_ACC[req_slot] == ACC_WO)  ? 16'h0000 : reg_q[req_slot];

    // a new read setup restarts the read and any other setup ends it, as a control pipe aborts the old one
    always_comb begin
        rd_state_d = rd_state_q;
        rd_word_d  = rd_word_q;
        case (rd_state_q)
            RD_IDLE: begin
                rd_state_d = RD_IDLE;
            end
            RD_LOW: begin
                if (RD_READY) begin
                    rd_state_d = RD_HIGH;                               // [RULE13]
                end
            end
            RD_HIGH: begin
                if (RD_READY) begin
                    rd_state_d = RD_IDLE;
                end
            end
            default: begin
                rd_state_d = RD_IDLE;
            end
        endcase
        if (rd_req) begin
            rd_state_d = RD_LOW;                                        // [RULE1]
            rd_word_d  = rd_src;
        end else if (SETUP_VALID) begin
            rd_state_d = RD_IDLE;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rd_state_q <= RD_IDLE;
            rd_word_q  <= 16'h0000;
            errrd_q    <= 1'b0;
        end else begin
            rd_state_q <= rd_state_d;
            rd_word_q  <= rd_word_d;
            errrd_q    <= rd_req && slot_is(req_slot, SL_ERR);
        end
    end

    // error flags are sticky in the serial core until this read strobe
    assign ERR_RD_STB = errrd_q;

    assign RD_VALID = (rd_state_q == RD_LOW) || (rd_state_q == RD_HIGH);
    assign RD_LAST  = rd_state_q == RD_HIGH;
    assign RD_BYTE  = (rd_state_q == RD_HIGH) ? rd_word_q[15:8] :
                      (rd_state_q == RD_LOW)  ? rd_word_q[7:0]  : 8'h00; // [RULE13]

endmodule : uartrb_bank

// File: tb/uartrb_bank_sva.sv
module uartrb_bank_sva
    import uartrb_pkg::*;
(
    // clock and reset
    input  wire logic               SYS_CLK,
    input  wire logic               RST_B,
    // requests
    input  wire logic               SETUP_VALID,
    input  wire uartrb_setup_t      SETUP_PKT,
    input  wire logic               LCODE_VALID,
    input  wire uartrb_lcode_t      LCODE,
    // read data
    input  wire logic               RD_VALID,
    input  wire logic [7:0]         RD_BYTE,
    input  wire logic               RD_LAST,
    input  wire logic               RD_READY,
    // results
    input  wire uartrb_ctrl_t       PORT_CTRL,
    input  wire logic [31:0]        BAUD_RATE,
    input  wire logic [NREG*16-1:0] CFG_WORDS,
    input  wire logic               REQ_REFUSED
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    wire       vend_ok = SETUP_VALID && SETUP_PKT.request == REQ_REG && SETUP_PKT.index[15:8] == IDX_HI_ZERO;
    wire       wr_take = vend_ok && SETUP_PKT.req_type == REQT_WR;
    wire       rd_take = vend_ok && SETUP_PKT.req_type == REQT_RD && SETUP_PKT.length == RD_LEN;
    wire [7:0] waddr   = SETUP_PKT.index[7:0];
    wire       lc_ok   = LCODE_VALID && (LCODE.stop == 8'h00 || LCODE.stop == 8'h02) && LCODE.parity <= 8'h04
                         && LCODE.bits >= 8'h07 && LCODE.bits <= 8'h09;

    ////////////////////////////////////////////////////////////////////////////////
    sequence lo_taken;
        RD_VALID && !RD_LAST && RD_READY && !SETUP_VALID;
    endsequence
    sequence hi_taken;
        RD_VALID && RD_LAST && RD_READY && !SETUP_VALID;
    endsequence

    rd_first_lo_a: assert property (rd_take |=> RD_VALID && !RD_LAST)
        else $error("read did not open with the low byte");
    rd_hi_next_a: assert property (lo_taken |=> RD_VALID && RD_LAST)
        else $error("high byte did not follow the low byte");
    rd_two_bytes_a: assert property (lo_taken ##1 hi_taken |=> !RD_VALID)
        else $error("read data ran past two bytes");
    rd_hold_a: assert property (RD_VALID && !RD_READY && !SETUP_VALID |=> RD_VALID && $stable(RD_BYTE))
        else $error("offered read byte changed before it was taken");
    wr_enable_a: assert property (wr_take && waddr == A_PORT_EN |=>
        CFG_WORDS[15:0] == ($past(SETUP_PKT.value) & M_EN) && PORT_CTRL.rx_en == $past(SETUP_PKT.value[1]))
        else $error("enable write not applied");
    wr_format_a: assert property (wr_take && waddr == A_CHAR_FMT |=>
        {PORT_CTRL.stop_two, PORT_CTRL.parity, PORT_CTRL.data_bits} == $past(SETUP_PKT.value[7:0]))
        else $error("format write not decoded");
    wr_wide_a: assert property (wr_take && waddr == A_BRK_DUR |=> CFG_WORDS[96 +: 16] == $past(SETUP_PKT.value))
        else $error("sixteen bit register lost bits");
    unmapped_wr_a: assert property (wr_take && waddr inside {8'h41, 8'h44, 8'h53} && !LCODE_VALID |=>
        REQ_REFUSED && $stable(CFG_WORDS))
        else $error("unmapped write changed state or was not refused");
    line_coding_a: assert property (lc_ok && !wr_take |=> BAUD_RATE == $past(LCODE.baud) &&
        CFG_WORDS[SL_FMT*16 +: 8] == {$past(LCODE.stop == 8'h02), $past(LCODE.parity[2:0]), $past(LCODE.bits[3:0])})
        else $error("line coding did not reach the format");
    reset_value_a: assert property ($rose(RST_B) |->
        CFG_WORDS[SL_FMT*16 +: 16] == RST_CHAR_FMT && CFG_WORDS[15:0] == RST_ZERO && BAUD_RATE == 32'h0)
        else $error("wrong value after reset");
    decode_a: assert property (PORT_CTRL == {CFG_WORDS[1:0], CFG_WORDS[SL_FMT*16 +: 8]})
        else $error("control outputs disagree with registers");
endmodule : uartrb_bank_sva

bind uartrb_bank uartrb_bank_sva uartrb_bank_sva_inst (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .SETUP_VALID(SETUP_VALID),
    .SETUP_PKT(SETUP_PKT), .LCODE_VALID(LCODE_VALID), .LCODE(LCODE), .RD_VALID(RD_VALID), .RD_BYTE(RD_BYTE),
    .RD_LAST(RD_LAST), .RD_READY(RD_READY), .PORT_CTRL(PORT_CTRL), .BAUD_RATE(BAUD_RATE), .CFG_WORDS(CFG_WORDS),
    .REQ_REFUSED(REQ_REFUSED));

// File: tb/uartrb_host_model.sv
module uartrb_host_model
    import uartrb_pkg::*;
(
    // clock
    input  wire logic          SYS_CLK,
    // setup stage
    output logic               setup_valid,
    output uartrb_setup_t      setup_pkt,
    // read data stage
    input  wire logic          rd_valid,
    input  wire logic [7:0]    rd_byte,
    input  wire logic          rd_last,
    output logic               rd_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        setup_valid = 1'b0;
        setup_pkt = '0;
        rd_ready = 1'b0;
    end

    // setup has no handshake: present for exactly one taking cycle
    task automatic send(input logic [7:0] rtype, input logic [7:0] addr, input logic [15:0] val,
                        input logic [15:0] len);
        @(negedge SYS_CLK);
        setup_pkt = '{rtype, REQ_REG, val, {IDX_HI_ZERO, addr}, len};
        setup_valid = 1'b1;
        @(negedge SYS_CLK);
        setup_valid = 1'b0;
        // released fields must not look like a request
        setup_pkt = ~setup_pkt;
    endtask : send

    task automatic read_reg(input logic [7:0] addr, input logic [15:0] len, input logic slow,
                            output logic [15:0] data, output logic got);
        int n;
        data = 16'h0000;
        got = 1'b0;
        send(REQT_RD, addr, 16'h0000, len);
        for (int i = 0; i < 2; i++) begin
            rd_ready = !slow;
            n = 0;
            while (rd_valid !== 1'b1 && n < 4) begin
                @(negedge SYS_CLK);
                n++;
            end
            if (rd_valid !== 1'b1 || rd_last !== (i == 1)) return;
            data[i*8 +: 8] = rd_byte;
            if (slow) begin
                @(negedge SYS_CLK);
                rd_ready = 1'b1;
            end
            @(negedge SYS_CLK);
        end
        rd_ready = 1'b0;
        got = (rd_valid === 1'b0);
    endtask : read_reg
endmodule : uartrb_host_model

// File: tb/uartrb_bank_tb_top.sv
module uartrb_bank_tb_top
    import uartrb_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic               sys_clk, rst_b, setup_valid, rd_valid, rd_last, rd_ready, lcode_valid, got;
    logic               pin_set_stb, pin_clr_stb, txq_flush_stb, rxq_flush_stb, err_rd_stb, req_refused;
    logic [7:0]         rd_byte;
    logic [15:0]        line_err, pin_level, txq_level, rxq_level, pin_wr_data, rdata;
    logic [31:0]        baud_rate;
    logic [NREG*16-1:0] cfg_words;
    uartrb_setup_t      setup_pkt;
    uartrb_lcode_t      lcode;
    uartrb_ctrl_t       port_ctrl;
    int                 fail_count = 0;
    int                 check_count = 0;
    logic [7:0]         fmts [6] = '{8'h08, 8'h17, 8'h29, 8'hB7, 8'hC8, 8'h47};

    uartrb_bank uartrb_bank_inst (.SYS_CLK(sys_clk), .RST_B(rst_b), .SETUP_VALID(setup_valid), .SETUP_PKT(setup_pkt),
        .RD_VALID(rd_valid), .RD_BYTE(rd_byte), .RD_LAST(rd_last), .RD_READY(rd_ready), .LCODE_VALID(lcode_valid),
        .LCODE(lcode), .LINE_ERR(line_err), .PIN_LEVEL(pin_level), .TXQ_LEVEL(txq_level), .RXQ_LEVEL(rxq_level),
        .PORT_CTRL(port_ctrl), .BAUD_RATE(baud_rate), .CFG_WORDS(cfg_words), .PIN_SET_STB(pin_set_stb),
        .PIN_CLR_STB(pin_clr_stb), .PIN_WR_DATA(pin_wr_data), .TXQ_FLUSH_STB(txq_flush_stb),
        .RXQ_FLUSH_STB(rxq_flush_stb), .ERR_RD_STB(err_rd_stb), .REQ_REFUSED(req_refused));
    uartrb_host_model uartrb_host_model_inst (.SYS_CLK(sys_clk), .setup_valid(setup_valid), .setup_pkt(setup_pkt),
        .rd_valid(rd_valid), .rd_byte(rd_byte), .rd_last(rd_last), .rd_ready(rd_ready));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_val(input logic [31:0] act, input logic [31:0] exp);
        check_count++;
        if (act !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
        end
    endtask : check_val
    task automatic test_end(input string name);
        $display("test %s ended, mismatches so far %0d", name, fail_count);
    endtask : test_end
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        uartrb_host_model_inst.send(REQT_WR, a, v, 16'h0000);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic slow);
        uartrb_host_model_inst.read_reg(a, RD_LEN, slow, rdata, got);
        check_val({31'h0, got}, 32'h1);
        check_val({16'h0, rdata}, {16'h0, exp});
    endtask : rd
    task automatic lc(input logic [31:0] b, input logic [7:0] s, input logic [7:0] p, input logic [7:0] n);
        @(negedge sys_clk);
        lcode = '{b, s, p, n};
        lcode_valid = 1'b1;
        @(negedge sys_clk);
        lcode_valid = 1'b0;
        lcode = ~lcode;
    endtask : lc
    task automatic test_done();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        test_done();
    end
    initial begin
        rst_b = 1'b0;
        lcode_valid = 1'b0;
        lcode = '0;
        line_err = 16'hFFFF;
        pin_level = 16'h00AA;
        txq_level = 16'hFFFF;
        rxq_level = 16'h0123;
        repeat (12) @(negedge sys_clk);
        rst_b = 1'b1;
        rd(A_PORT_EN, RST_ZERO, 1'b0);
        rd(A_CHAR_FMT, RST_CHAR_FMT, 1'b1);
        check_val(32'(port_ctrl), 32'h008);
        test_end("reset");
        for (int v = 0; v < 4; v++) begin
            wr(A_PORT_EN, 16'(v));
            check_val(32'(port_ctrl[9:8]), 32'(v));
            rd(A_PORT_EN, 16'(v), 1'b0);
        end
        test_end("enable");
        foreach (fmts[i]) begin
            wr(A_CHAR_FMT, {8'h00, fmts[i]});
            check_val(32'(port_ctrl[7:0]), 32'(fmts[i]));
        end
        rd(A_CHAR_FMT, 16'h0047, 1'b1);
        test_end("format");
        lc(32'd115200, 8'h02, 8'h01, 8'h09);
        check_val(baud_rate, 32'd115200);
        rd(A_CHAR_FMT, 16'h0099, 1'b0);
        lc(32'd9600, 8'h01, 8'h00, 8'h08);
        check_val({port_ctrl[7:0], baud_rate[23:0]}, 32'h99_01C200);
        test_end("line_coding");
        wr(A_BRK_DUR, 16'hA5C3);
        rd(A_BRK_DUR, 16'hA5C3, 1'b1);
        wr(8'h53, 16'h00FF);
        check_val(32'(req_refused), 32'h1);
        rd(8'h53, 16'h0000, 1'b0);
        rd(A_LINE_ERR, 16'hFFFF & M_ERR, 1'b0);
        wr(A_PIN_SET, 16'h0015);
        check_val(32'({pin_set_stb, pin_wr_data}), 32'h10015);
        wr(A_TXQ_FLUSH, 16'h0001);
        check_val(32'({txq_flush_stb, rxq_flush_stb, pin_clr_stb}), 32'h4);
        wr(A_RXQ_FLUSH, 16'h0001);
        check_val(32'({txq_flush_stb, rxq_flush_stb, pin_clr_stb}), 32'h2);
        rd(A_RXQ_LVL, 16'h0123, 1'b0);
        uartrb_host_model_inst.send(REQT_RD, A_PORT_EN, 16'h0000, 16'h0001);
        check_val(32'({req_refused, rd_valid}), 32'h2);
        test_end("map");
        @(negedge sys_clk);
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_b = 1'b1;
        check_val(baud_rate, 32'h0);
        rd(A_BRK_DUR, RST_ZERO, 1'b0);
        test_end("second_reset");
        test_done();
    end
endmodule : uartrb_bank_tb_top
